// *** rtl/hvsp_dev.sv ***
`timescale 1ns/10ps
module hvsp_dev #(
  parameter int FLASH_WORDS = 2048,
  parameter int EE_BYTES = 256,
  parameter int PAGE_WORDS = 16
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // fuse
  input wire logic eeprom_preserve_fuse,
  // link
  hvsp_if.dev link,
  // status
  output logic prog_mode,
  output logic lock_bits_cleared
);
  // ****************************************
  // synchronisers
  // ****************************************
  logic [6:0] s1_reg, s2_reg;
  logic sck_d_reg;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      s1_reg <= 7'h0;
      s2_reg <= 7'h0;
      sck_d_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= {link.select_pin[2], link.hv_reset, link.prog_serial_clock, link.prog_data_in,
        link.prog_instr_in, link.select_pin[1:0]};
      s2_reg <= s1_reg;
      sck_d_reg <= s2_reg[4];
    end
  end
  wire hv = s2_reg[5];
  wire sck_rise = s2_reg[4] & ~sck_d_reg;
  // ****************************************
  // memories
  // ****************************************
  logic [15:0] flash_mem [FLASH_WORDS];
  logic [7:0] ee_mem [EE_BYTES];
  logic [15:0] page_buf [PAGE_WORDS];
  typedef enum {HS_OFF, HS_LATCH, HS_ON, HS_BUSY} hvsp_state_t;
  hvsp_state_t st_reg, st_next;
  logic [10:0] di_reg, di_next, ii_reg, ii_next, do_reg, do_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] cmd_reg, cmd_next, alo_reg, alo_next, ahi_reg, ahi_next;
  logic [7:0] dlo_reg, dlo_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [1:0] pgf_reg, pgf_next;
  logic out_reg, out_next, oe_reg, oe_next, mode_reg, mode_next, lock_reg, lock_next;
  logic erase_job_reg, erase_job_next;
  logic wr_pb, wr_pbh, wr_fl, wr_ee, do_erase;
  logic [7:0] fi, fd;
  always_comb
  begin
    st_next = st_reg;
    di_next = di_reg;
    ii_next = ii_reg;
    do_next = do_reg;
    bit_next = bit_reg;
    cmd_next = cmd_reg;
    alo_next = alo_reg;
    ahi_next = ahi_reg;
    dlo_next = dlo_reg;
    cnt_next = cnt_reg;
    pgf_next = pgf_reg;
    out_next = out_reg;
    oe_next = oe_reg;
    mode_next = mode_reg;
    lock_next = lock_reg;
    erase_job_next = erase_job_reg;
    wr_pb = 1'b0;
    wr_pbh = 1'b0;
    wr_fl = 1'b0;
    wr_ee = 1'b0;
    do_erase = 1'b0;
    fi = ii_reg[9:2];
    fd = di_reg[9:2];
    if (!hv)
    begin
      st_next = HS_OFF;
      oe_next = 1'b0;
      mode_next = 1'b0;
      cnt_next = 8'h0;
    end
    else
      case (st_reg)
        HS_OFF:
        begin
          st_next = HS_LATCH;
          cnt_next = 8'h0;
        end
        HS_LATCH:
        begin
          cnt_next = cnt_reg + 8'h1;
          if (cnt_reg == 8'(hvsp_pkg::LATCH_CYC))
          begin
            if ({s2_reg[6], s2_reg[1:0]} == hvsp_pkg::ENTRY_PATTERN)
            begin
              st_next = HS_ON;
              oe_next = 1'b1;
              out_next = 1'b1;
              mode_next = 1'b1;
              bit_next = 4'h0;
            end
          end
        end
        HS_ON:
          if (sck_rise)
          begin
            di_next = {di_reg[9:0], s2_reg[3]};
            ii_next = {ii_reg[9:0], s2_reg[2]};
            do_next = {do_reg[9:0], 1'b0};
            out_next = do_reg[10];
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'(hvsp_pkg::FRAME_BITS - 1))
            begin
              bit_next = 4'h0;
              fi = ii_reg[8:1];
              fd = di_reg[8:1];
              if (fi == hvsp_pkg::II_LOAD_CMD)
              begin
                cmd_next = fd;
                pgf_next = 2'h0;
              end
              else if (fi == hvsp_pkg::II_ADDR_LO)
                alo_next = fd;
              else if (fi == hvsp_pkg::II_ADDR_HI)
                ahi_next = fd;
              else if (fi == hvsp_pkg::II_DATA_LO || fi == hvsp_pkg::II_DATA_HI)
                dlo_next = fd;
              else if (fi == hvsp_pkg::II_LATCH_LO)
                wr_pb = 1'b1;
              else if (fi == hvsp_pkg::II_LATCH_HI)
                wr_pbh = 1'b1;
              else if (fi == hvsp_pkg::II_PROG)
                pgf_next = 2'h1;
              else if (fi == hvsp_pkg::II_IDLE && pgf_reg == 2'h1)
              begin
                pgf_next = 2'h0;
                st_next = HS_BUSY;
                out_next = 1'b0;
                cnt_next = 8'h0;
                erase_job_next = (cmd_reg == hvsp_pkg::CMD_ERASE);
              end
              else if (fi == hvsp_pkg::II_RD_LO && cmd_reg == hvsp_pkg::CMD_READ_FLASH)
                do_next = {1'b0, flash_mem[{ahi_reg[2:0], alo_reg}][7:0], 2'h0};
              else if (fi == hvsp_pkg::II_RD_HI && cmd_reg == hvsp_pkg::CMD_READ_FLASH)
                do_next = {1'b0, flash_mem[{ahi_reg[2:0], alo_reg}][15:8], 2'h0};
              if (fi == hvsp_pkg::II_RD_EE && cmd_reg == hvsp_pkg::CMD_READ_EE)
                do_next = {1'b0, ee_mem[alo_reg], 2'h0};
            end
          end
        HS_BUSY:
        begin
          out_next = 1'b0;
          cnt_next = cnt_reg + 8'h1;
          if (cnt_reg == 8'(hvsp_pkg::PROG_CYC))
          begin
            st_next = HS_ON;
            out_next = 1'b1;
            if (erase_job_reg)
            begin
              do_erase = 1'b1;
              lock_next = 1'b1;
            end
            else if (cmd_reg == hvsp_pkg::CMD_WRITE_FLASH)
              wr_fl = 1'b1;
            else if (cmd_reg == hvsp_pkg::CMD_WRITE_EE)
              wr_ee = 1'b1;
          end
        end
        default:
          st_next = HS_OFF;
      endcase
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= HS_OFF;
      di_reg <= 11'h0;
      ii_reg <= 11'h0;
      do_reg <= 11'h0;
      bit_reg <= 4'h0;
      cmd_reg <= 8'h0;
      alo_reg <= 8'h0;
      ahi_reg <= 8'h0;
      dlo_reg <= 8'h0;
      cnt_reg <= 8'h0;
      pgf_reg <= 2'h0;
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      mode_reg <= 1'b0;
      lock_reg <= 1'b0;
      erase_job_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      di_reg <= di_next;
      ii_reg <= ii_next;
      do_reg <= do_next;
      bit_reg <= bit_next;
      cmd_reg <= cmd_next;
      alo_reg <= alo_next;
      ahi_reg <= ahi_next;
      dlo_reg <= dlo_next;
      cnt_reg <= cnt_next;
      pgf_reg <= pgf_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      mode_reg <= mode_next;
      lock_reg <= lock_next;
      erase_job_reg <= erase_job_next;
    end
  end
  // ****************************************
  // arrays: no reset, contents are nonvolatile
  // ****************************************
  always_ff @(posedge sys_clk)
  begin
    if (wr_pb)
      page_buf[ee_sel() ? {2'h0, alo_reg[1:0]} : alo_reg[3:0]][7:0] <= dlo_reg;
    if (wr_pbh && !ee_sel())
      page_buf[alo_reg[3:0]][15:8] <= dlo_reg;
    for (int i = 0; i < FLASH_WORDS; i++)
      if (do_erase)
        flash_mem[i] <= 16'hffff;
    for (int i = 0; i < EE_BYTES; i++)
      if (do_erase && !eeprom_preserve_fuse)
        ee_mem[i] <= 8'hff;
    for (int i = 0; i < PAGE_WORDS; i++)
    begin
      if (wr_fl)
        flash_mem[{ahi_reg[2:0], alo_reg[7:4], 4'(i)}] <= page_buf[i];
      if (wr_ee && i < 4)
        ee_mem[{alo_reg[7:2], 2'(i)}] <= page_buf[i][7:0];
    end
  end
  function automatic logic ee_sel();
    ee_sel = (cmd_reg == hvsp_pkg::CMD_WRITE_EE);
  endfunction
  assign link.prog_data_out = out_reg;
  assign link.prog_data_out_oe = oe_reg;
  assign prog_mode = mode_reg;
  assign lock_bits_cleared = lock_reg;
endmodule

// *** rtl/hvsp_if.sv ***
`timescale 1ns/10ps
interface hvsp_if;
  logic hv_reset;
  logic prog_serial_clock;
  logic prog_data_in;
  logic prog_instr_in;
  logic [2:0] select_out;
  logic [2:0] select_oe;
  logic prog_data_out;
  logic prog_data_out_oe;
  // pin 2 is shared: device drive wins when enabled, else programmer's
  logic [2:0] select_pin;
  assign select_pin[1:0] = select_oe[1:0] & select_out[1:0];
  assign select_pin[2] = prog_data_out_oe ? prog_data_out : (select_oe[2] & select_out[2]);
  modport dev (input hv_reset, prog_serial_clock, prog_data_in, prog_instr_in, select_pin,
    output prog_data_out, prog_data_out_oe);
  modport prog (output hv_reset, prog_serial_clock, prog_data_in, prog_instr_in,
    select_out, select_oe, input select_pin);
endinterface

// *** rtl/hvsp_pkg.sv ***
package hvsp_pkg;
  // ****************************************
  // frame and timing
  // ****************************************
  localparam int FRAME_BITS = 11;
  localparam int SYS_CLK_MHZ = 40;
  localparam int CLK_MIN_PERIOD_NS = 220;
  localparam int ENTRY_CLOCKS = 6;
  localparam int SELECT_SETUP_NS = 100;
  localparam int LATCH_TIME_NS = 100;
  localparam int ENTRY_WAIT_US = 50;
  localparam int ENTRY_WAIT_CYC = ENTRY_WAIT_US * SYS_CLK_MHZ;
  localparam int SETUP_CYC = (SELECT_SETUP_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int LATCH_CYC = (LATCH_TIME_NS * SYS_CLK_MHZ + 999) / 1000;
  // last count of each half period of the link clock made by the programmer; a half lasts one cycle more
  localparam int HALF_CYC = (CLK_MIN_PERIOD_NS * SYS_CLK_MHZ + 1999) / 2000;
  localparam int PROG_CYC = 64;
  localparam int WORD_W = 16;
  localparam int FLASH_AW = 11;
  localparam int EE_AW = 8;
  localparam int PAGE_AW = 4;
  localparam logic [2:0] ENTRY_PATTERN = 3'h0;
  // ****************************************
  // commands: data-input part with instruction-input part of a frame
  // ****************************************
  localparam logic [7:0] CMD_WRITE_FLASH = 8'h10;
  localparam logic [7:0] CMD_READ_FLASH = 8'h02;
  localparam logic [7:0] CMD_WRITE_EE = 8'h11;
  localparam logic [7:0] CMD_READ_EE = 8'h03;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] II_LOAD_CMD = 8'h4c;
  localparam logic [7:0] II_ADDR_LO = 8'h0c;
  localparam logic [7:0] II_ADDR_HI = 8'h1c;
  localparam logic [7:0] II_DATA_LO = 8'h2c;
  localparam logic [7:0] II_DATA_HI = 8'h3c;
  localparam logic [7:0] II_LATCH_LO = 8'h6d;
  localparam logic [7:0] II_LATCH_HI = 8'h7d;
  localparam logic [7:0] II_PROG = 8'h64;
  localparam logic [7:0] II_IDLE = 8'h6c;
  localparam logic [7:0] II_RD_LO = 8'h68;
  localparam logic [7:0] II_RD_HI = 8'h78;
  localparam logic [7:0] II_RD_EE = 8'h68;
endpackage

// *** rtl/hvsp_prog.sv ***
`timescale 1ns/10ps
module hvsp_prog (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // user side
  input wire logic start,
  input wire logic frame_valid,
  input wire logic [7:0] frame_data,
  input wire logic [7:0] frame_instr,
  input wire logic wait_ready,
  output logic frame_ready,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic in_mode,
  // link
  hvsp_if.prog link
);
  typedef enum {PS_IDLE, PS_PULSE, PS_SETUP, PS_LATCH, PS_WAIT, PS_READY, PS_SHIFT,
    PS_POLL} hvsp_pstate_t;
  hvsp_pstate_t st_reg, st_next;
  logic [15:0] cnt_reg, cnt_next;
  logic [3:0] bit_reg, bit_next;
  logic [10:0] di_reg, di_next, ii_reg, ii_next;
  logic [10:0] rx_reg, rx_next;
  logic sck_reg, sck_next, hv_reg, hv_next, seloe_reg, seloe_next;
  logic rdy_reg, rdy_next, rv_reg, rv_next, mode_reg, mode_next, pw_reg, pw_next;
  logic [1:0] sdo_s_reg;
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      sdo_s_reg <= 2'h0;
    else
      sdo_s_reg <= {sdo_s_reg[0], link.select_pin[2]};
  end
  always_comb
  begin
    st_next = st_reg;
    cnt_next = cnt_reg + 16'h1;
    bit_next = bit_reg;
    di_next = di_reg;
    ii_next = ii_reg;
    rx_next = rx_reg;
    sck_next = sck_reg;
    hv_next = hv_reg;
    seloe_next = seloe_reg;
    rdy_next = 1'b0;
    rv_next = 1'b0;
    mode_next = mode_reg;
    pw_next = pw_reg;
    case (st_reg)
      PS_IDLE:
        if (start)
        begin
          st_next = PS_PULSE;
          cnt_next = 16'h0;
          bit_next = 4'h0;
          seloe_next = 1'b1;
        end
      PS_PULSE:
        if (cnt_reg == 16'(hvsp_pkg::HALF_CYC))
        begin
          cnt_next = 16'h0;
          sck_next = ~sck_reg;
          if (sck_reg)
            bit_next = bit_reg + 4'h1;
          if (sck_reg && bit_reg == 4'(hvsp_pkg::ENTRY_CLOCKS - 1))
            st_next = PS_SETUP;
        end
      PS_SETUP:
        if (cnt_reg == 16'(hvsp_pkg::SETUP_CYC))
        begin
          hv_next = 1'b1;
          cnt_next = 16'h0;
          st_next = PS_LATCH;
        end
      PS_LATCH:
        if (cnt_reg == 16'(2 * hvsp_pkg::LATCH_CYC + 4))
        begin
          seloe_next = 1'b0;
          cnt_next = 16'h0;
          st_next = PS_WAIT;
        end
      PS_WAIT:
        if (cnt_reg == 16'(hvsp_pkg::ENTRY_WAIT_CYC))
        begin
          st_next = PS_READY;
          mode_next = 1'b1;
          rdy_next = 1'b1;
        end
      PS_READY:
      begin
        rdy_next = ~frame_valid;
        if (frame_valid)
        begin
          di_next = {1'b0, frame_data, 2'h0};
          ii_next = {1'b0, frame_instr, 2'h0};
          pw_next = wait_ready;
          bit_next = 4'h0;
          cnt_next = 16'h0;
          st_next = PS_SHIFT;
        end
      end
      PS_SHIFT:
        if (cnt_reg == 16'(hvsp_pkg::HALF_CYC))
        begin
          cnt_next = 16'h0;
          sck_next = ~sck_reg;
          if (!sck_reg)
            rx_next = {rx_reg[9:0], sdo_s_reg[1]};
          else
          begin
            di_next = {di_reg[9:0], 1'b0};
            ii_next = {ii_reg[9:0], 1'b0};
            bit_next = bit_reg + 4'h1;
            if (bit_reg == 4'(hvsp_pkg::FRAME_BITS - 1))
            begin
              rv_next = 1'b1;
              st_next = pw_reg ? PS_POLL : PS_READY;
              rdy_next = ~pw_reg;
            end
          end
        end
      PS_POLL:
        if (cnt_reg > 16'h8 && sdo_s_reg[1])
        begin
          st_next = PS_READY;
          rdy_next = 1'b1;
        end
      default:
        st_next = PS_IDLE;
    endcase
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_reg <= PS_IDLE;
      cnt_reg <= 16'h0;
      bit_reg <= 4'h0;
      di_reg <= 11'h0;
      ii_reg <= 11'h0;
      rx_reg <= 11'h0;
      sck_reg <= 1'b0;
      hv_reg <= 1'b0;
      seloe_reg <= 1'b0;
      rdy_reg <= 1'b0;
      rv_reg <= 1'b0;
      mode_reg <= 1'b0;
      pw_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      cnt_reg <= cnt_next;
      bit_reg <= bit_next;
      di_reg <= di_next;
      ii_reg <= ii_next;
      rx_reg <= rx_next;
      sck_reg <= sck_next;
      hv_reg <= hv_next;
      seloe_reg <= seloe_next;
      rdy_reg <= rdy_next;
      rv_reg <= rv_next;
      mode_reg <= mode_next;
      pw_reg <= pw_next;
    end
  end
  // clock period from divider, always above the 220 ns floor
  assign link.prog_serial_clock = sck_reg;
  assign link.prog_data_in = di_reg[10];
  assign link.prog_instr_in = ii_reg[10];
  assign link.hv_reset = hv_reg;
  assign link.select_out = hvsp_pkg::ENTRY_PATTERN;
  assign link.select_oe = {3{seloe_reg}};
  assign frame_ready = rdy_reg;
  // each bit is captured one link clock period, at the next rising edge, after the device launches it
  assign read_data = rx_reg[8:1];
  assign read_valid = rv_reg;
  assign in_mode = mode_reg;
endmodule

// *** testbench/hv_serial_programming_port_tb.sv ***
`timescale 1ns/10ps
module hv_serial_programming_port_tb;
  // ****************************************
  // stimulus and instances
  // ****************************************
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic keep_ee = 1'b0;
  logic start = 1'b0;
  logic frame_valid = 1'b0;
  logic wait_ready = 1'b0;
  logic [7:0] frame_data = 8'h00;
  logic [7:0] frame_instr = 8'h00;
  logic frame_ready, read_valid, in_mode, prog_mode, lock_clr;
  logic [7:0] read_data, rd;
  logic [15:0] word;
  int fail_count = 0;
  int samples_checked = 0;
  int n;
  always #12.5 sys_clk = ~sys_clk;
  hvsp_if link();
  hvsp_dev u_hvsp_dev (.sys_clk(sys_clk), .rstn(rstn), .eeprom_preserve_fuse(keep_ee),
    .link(link), .prog_mode(prog_mode), .lock_bits_cleared(lock_clr));
  hvsp_prog u_hvsp_prog (.sys_clk(sys_clk), .rstn(rstn), .start(start),
    .frame_valid(frame_valid), .frame_data(frame_data), .frame_instr(frame_instr),
    .wait_ready(wait_ready), .frame_ready(frame_ready), .read_data(read_data),
    .read_valid(read_valid), .in_mode(in_mode), .link(link));
  hvsp_checker u_hvsp_checker (.sys_clk(sys_clk), .rstn(rstn), .hv_reset(link.hv_reset),
    .prog_serial_clock(link.prog_serial_clock), .prog_data_in(link.prog_data_in),
    .prog_instr_in(link.prog_instr_in), .select_oe(link.select_oe),
    .select_pin(link.select_pin), .prog_data_out(link.prog_data_out),
    .prog_data_out_oe(link.prog_data_out_oe));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checked=%0d errors=%0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // hold the frame until taken, then wait for its read byte
  task automatic frame(input logic [7:0] d, input logic [7:0] i, input logic w = 1'b0);
    int k;
    @(posedge sys_clk);
    {frame_valid, frame_data, frame_instr, wait_ready} <= {1'b1, d, i, w};
    k = 0;
    do @(posedge sys_clk); while (frame_ready !== 1'b1 && ++k < 4000);
    if (k >= 4000) fail_count++;
    frame_valid <= 1'b0;
    k = 0;
    do @(posedge sys_clk); while (read_valid !== 1'b1 && ++k < 4000);
    if (k >= 4000) fail_count++;
    rd = read_data;
  endtask
  task automatic cmd(input logic [7:0] c);
    frame(c, hvsp_pkg::II_LOAD_CMD);
  endtask
  task automatic erase();
    frame(hvsp_pkg::CMD_ERASE, hvsp_pkg::II_LOAD_CMD);
    frame(8'h00, hvsp_pkg::II_PROG);
    frame(8'h00, hvsp_pkg::II_IDLE, 1'b1);
    cmd(hvsp_pkg::CMD_NOP);
  endtask
  task automatic load_word(input logic [7:0] a, input logic [15:0] v);
    frame(a, hvsp_pkg::II_ADDR_LO);
    frame(v[7:0], hvsp_pkg::II_DATA_LO);
    frame(8'h00, hvsp_pkg::II_LATCH_LO);
    frame(8'h00, hvsp_pkg::II_IDLE);
    frame(v[15:8], hvsp_pkg::II_DATA_HI);
    frame(8'h00, hvsp_pkg::II_LATCH_HI);
    frame(8'h00, hvsp_pkg::II_IDLE);
  endtask
  // byte appears in the frame after the read frame
  task automatic read_word(input logic [7:0] a);
    frame(a, hvsp_pkg::II_ADDR_LO);
    frame(8'h00, hvsp_pkg::II_RD_LO);
    frame(8'h00, hvsp_pkg::II_IDLE);
    word[7:0] = rd;
    frame(8'h00, hvsp_pkg::II_RD_HI);
    frame(8'h00, hvsp_pkg::II_IDLE);
    word[15:8] = rd;
  endtask
  task automatic read_ee(input logic [7:0] a);
    cmd(hvsp_pkg::CMD_READ_EE);
    frame(a, hvsp_pkg::II_ADDR_LO);
    frame(8'h00, hvsp_pkg::II_ADDR_HI);
    frame(8'h00, hvsp_pkg::II_RD_EE);
    frame(8'h00, hvsp_pkg::II_IDLE);
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b1;
    @(posedge sys_clk);
    start <= 1'b0;
    n = 0;
    do @(posedge sys_clk); while (in_mode !== 1'b1 && ++n < 10000);
    check(16'(n >= hvsp_pkg::ENTRY_WAIT_CYC), 16'h1);
    check(in_mode, 16'h1);
    check(prog_mode, 16'h1);
    check(lock_clr, 16'h0);
    erase();
    check(lock_clr, 16'h1);
    // two words share one page and one programming cycle
    cmd(hvsp_pkg::CMD_WRITE_FLASH);
    load_word(8'h05, 16'hbeef);
    load_word(8'h06, 16'h1234);
    frame(8'h01, hvsp_pkg::II_ADDR_HI);
    frame(8'h00, hvsp_pkg::II_PROG);
    frame(8'h00, hvsp_pkg::II_IDLE, 1'b1);
    cmd(hvsp_pkg::CMD_NOP);
    cmd(hvsp_pkg::CMD_WRITE_EE);
    frame(8'h21, hvsp_pkg::II_ADDR_LO);
    frame(8'h00, hvsp_pkg::II_ADDR_HI);
    frame(8'h5a, hvsp_pkg::II_DATA_LO);
    frame(8'h00, hvsp_pkg::II_LATCH_LO);
    frame(8'h00, hvsp_pkg::II_IDLE);
    frame(8'h00, hvsp_pkg::II_PROG);
    frame(8'h00, hvsp_pkg::II_IDLE, 1'b1);
    cmd(hvsp_pkg::CMD_NOP);
    cmd(hvsp_pkg::CMD_READ_FLASH);
    frame(8'h01, hvsp_pkg::II_ADDR_HI);
    read_word(8'h05);
    check(word, 16'hbeef);
    // no command and no high address reload for the second word
    read_word(8'h06);
    check(word, 16'h1234);
    read_ee(8'h21);
    check(rd, 16'h5a);
    keep_ee <= 1'b1;
    erase();
    read_ee(8'h21);
    check(rd, 16'h5a);
    keep_ee <= 1'b0;
    erase();
    read_ee(8'h21);
    check(rd, 16'hff);
    cmd(hvsp_pkg::CMD_READ_FLASH);
    frame(8'h01, hvsp_pkg::II_ADDR_HI);
    read_word(8'h05);
    check(word, 16'hffff);
    end_sim();
  end
  // bounded by roughly five times the expected run
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    end_sim();
  end
endmodule

// *** testbench/hvsp_checker.sv ***
`timescale 1ns/10ps
module hvsp_checker (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // programmer side
  input wire logic hv_reset,
  input wire logic prog_serial_clock,
  input wire logic prog_data_in,
  input wire logic prog_instr_in,
  input wire logic [2:0] select_oe,
  input wire logic [2:0] select_pin,
  // device side
  input wire logic prog_data_out,
  input wire logic prog_data_out_oe
);
  // ****************************************
  // frame decode
  // ****************************************
  logic sclk_reg, sclk_next, done_reg, done_next, rise, prog_start;
  logic [2:0] pulse_reg, pulse_next;
  logic [3:0] bit_reg, bit_next;
  logic [11:0] wait_reg, wait_next;
  logic [10:0] sdi_reg, sdi_next, sii_reg, sii_next;
  logic [7:0] last_reg, last_next;
  assign rise = prog_serial_clock & ~sclk_reg;
  // a cycle starts on an idle frame right after a program frame
  assign prog_start = done_reg && sii_reg[9:2] == hvsp_pkg::II_IDLE
    && last_reg == hvsp_pkg::II_PROG;
  always_comb
  begin
    sclk_next = prog_serial_clock;
    pulse_next = (rise && !hv_reset && pulse_reg != 3'h7) ? pulse_reg + 3'h1 : pulse_reg;
    wait_next = !hv_reset ? 12'h0 : ((wait_reg == 12'hfff) ? wait_reg : wait_reg + 12'h1);
    last_next = done_reg ? sii_reg[9:2] : last_reg;
    sdi_next = sdi_reg;
    sii_next = sii_reg;
    done_next = 1'b0;
    bit_next = hv_reset ? bit_reg : 4'h0;
    if (hv_reset && rise)
    begin
      sdi_next = {sdi_reg[9:0], prog_data_in};
      sii_next = {sii_reg[9:0], prog_instr_in};
      done_next = bit_reg == 4'ha;
      bit_next = (bit_reg == 4'ha) ? 4'h0 : bit_reg + 4'h1;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
      {sclk_reg, done_reg, pulse_reg, bit_reg, wait_reg, sdi_reg, sii_reg, last_reg} <= '0;
    else
      {sclk_reg, done_reg, pulse_reg, bit_reg, wait_reg, sdi_reg, sii_reg, last_reg} <=
        {sclk_next, done_next, pulse_next, bit_next, wait_next, sdi_next, sii_next, last_next};
  end
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence seq_busy;
    ##[1:20] (!prog_data_out) [*8] ##[1:120] prog_data_out;
  endsequence
  a_clock_period_min: assert property (
    $rose(prog_serial_clock) |=> (!$rose(prog_serial_clock)) [*8])
    else $error("link clock period too short");
  a_entry_pulse_count: assert property (
    $rose(hv_reset) |-> pulse_reg >= 3'h6)
    else $error("too few clock pulses before high voltage");
  a_select_setup: assert property (
    $rose(hv_reset) |-> $past(select_pin, 1) == 3'h0 && $past(select_pin, 4) == 3'h0
      && $past(select_oe, 4) == 3'h7 && select_oe == 3'h7)
    else $error("select pattern not set up before high voltage");
  a_select_hold: assert property (
    $rose(hv_reset) |-> (select_pin == 3'h0 && select_oe == 3'h7 && !prog_data_out_oe) [*4])
    else $error("select pattern disturbed during latch time");
  a_dout_drive: assert property (
    $rose(hv_reset) |-> ##[1:40] prog_data_out_oe)
    else $error("data out not driven after latch");
  a_select_release: assert property (
    $rose(prog_data_out_oe) |-> ##[0:20] !select_oe[2])
    else $error("shared select pin not released");
  a_entry_wait: assert property (
    $rose(prog_serial_clock) && hv_reset |-> wait_reg >= hvsp_pkg::ENTRY_WAIT_CYC)
    else $error("instruction before entry wait elapsed");
  a_busy_low: assert property (
    prog_start |-> seq_busy)
    else $error("data out not low then high around a cycle");
  a_poll_hold: assert property (
    prog_start |-> (!$rose(prog_serial_clock)) throughout seq_busy)
    else $error("clock ran while device busy");
  a_frame_shape: assert property (
    done_reg |-> sdi_reg[10] == 1'b0 && sdi_reg[1:0] == 2'h0
      && sii_reg[10] == 1'b0 && sii_reg[1:0] == 2'h0)
    else $error("frame padding bits not zero");
endmodule
